//--- core/ddrs_pkg.sv
// shared constants, carriers and decode helpers for the burst-of-two sram core
package ddrs_pkg;

  // ----------------------------------------------------------------
  // widths and storage
  // ----------------------------------------------------------------
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int ADDR_W = 4;
  localparam int MEM_DEPTH = 32;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int EVAL_PERIOD_NS = 20000;
  // longest spacing of impedance evaluations, so rounded down
  localparam logic [9:0] EVAL_CYCLES = 10'(EVAL_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [9:0] EVAL_CNT_RESET = 10'h000;
  localparam logic [9:0] EVAL_CNT_ONE = 10'h001;

  // ----------------------------------------------------------------
  // termination
  // ----------------------------------------------------------------
  localparam logic [3:0] TERM_RATIO_STRONG = 4'h3;
  localparam logic [3:0] TERM_RATIO_WEAK = 4'h6;
  localparam logic [9:0] RES_MIN_OHMS = 10'h0AF;
  localparam logic [9:0] RES_MAX_STRONG_OHMS = 10'h15E;
  localparam logic [9:0] RES_MAX_WEAK_OHMS = 10'h0FA;
  localparam logic [5:0] TERM_CODE_RESET = 6'h20;
  localparam logic [5:0] TERM_CODE_MAX = 6'h3F;
  localparam logic [5:0] TERM_CODE_MIN = 6'h00;
  localparam logic [5:0] TERM_CODE_STEP = 6'h01;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    PH_K_RISE = 1'b0,
    PH_KN_RISE = 1'b1
  } ddrs_phase_t;

  typedef struct packed {
    logic loadStrobe_n;
    logic readSel;
    logic [ADDR_W-1:0] addr;
  } ddrs_cmd_t;

  typedef struct packed {
    logic valid;
    logic readOp;
    logic [ADDR_W-1:0] addr;
  } ddrs_slot_t;

  localparam ddrs_slot_t SLOT_IDLE = ddrs_slot_t'(6'h00);

  // command pins to pipeline slot; a high load strobe is a deselect
  function automatic ddrs_slot_t decodeSlot(input ddrs_cmd_t c);
    ddrs_slot_t s;
    s.valid = ~c.loadStrobe_n;
    s.readOp = c.readSel;
    s.addr = c.addr;
    return s;
  endfunction : decodeSlot

  function automatic logic isReadCmd(input ddrs_cmd_t c);
    return ~c.loadStrobe_n & c.readSel;
  endfunction : isReadCmd

endpackage : ddrs_pkg

//--- core/ddrs_lane_merge.sv
// per-lane merge of incoming write data over the stored word
`timescale 1ns/10ps
module ddrs_lane_merge
  import ddrs_pkg::*;
(
  // words
  input wire logic [DATA_W-1:0] oldWord,
  input wire logic [DATA_W-1:0] newWord,
  // active-low lane strobes
  input wire logic [LANES-1:0] laneWriteStrobe_n,
  // result
  output logic [DATA_W-1:0] mergedWord
);

  // a high strobe keeps the stored lane untouched
  for (genvar g = 0; g < LANES; g++) begin : gLane
    assign mergedWord[g*LANE_W +: LANE_W] =
      laneWriteStrobe_n[g] ? oldWord[g*LANE_W +: LANE_W] : newWord[g*LANE_W +: LANE_W];
  end

endmodule : ddrs_lane_merge

//--- core/ddrs_core.sv
// burst-of-two common-io ddr sram core: command pipe, byte writes, termination control
// Function
// - input termination is always enabled
// - select low gives strong 0.3 termination
// - select high gives weak 0.6 termination
// - unconnected select reads high, weak range
// - periodic one-step termination impedance recalibration
// - select low, drivers off after idle/write
// - select high, drivers off equally
// - lane stored both beats when strobed twice
// - lane stored first beat only
// - lane stored second beat only
// - no strobes means write aborted
// - four strobes gate four nine-bit lanes
// - read beats base then base plus one
// - load high loads nothing, deselect after bursts
// - command sampled on k; select high reads
// - high strobe leaves lane undisturbed
`timescale 1ns/10ps
module ddrs_core
  import ddrs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // command pins, sampled on k rising
  input wire ddrs_cmd_t cmdIn,
  // data pins
  input wire logic [DATA_W-1:0] dqIn,
  input wire logic [LANES-1:0] byteWriteStrobe_n,
  output logic [DATA_W-1:0] dqOut,
  output logic dqOe_n,
  // clock phase, high on the k-bar half
  output logic kBarPhase,
  // termination control
  input wire logic terminationRangeSelect,
  input wire logic terminationRangeSelectDriven,
  input wire logic [9:0] impedanceSetResistorOhms,
  input wire logic impedanceTooHigh,
  input wire logic impedanceTooLow,
  output logic termEnable,
  output logic termStrong,
  output logic [3:0] termRatioTenths,
  output logic termRangeOk,
  output logic [5:0] termCode
);

  // ----------------------------------------------------------------
  // half-cycle phase
  // ----------------------------------------------------------------
  ddrs_phase_t phase_q;
  ddrs_phase_t phase_d;
  logic kRise;

  // each k cycle is two mclk edges: k rising then k-bar rising
  assign phase_d = (phase_q == PH_K_RISE) ? PH_KN_RISE : PH_K_RISE;
  assign kRise = (phase_q == PH_K_RISE);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phase_q <= PH_K_RISE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------------------------------
  // command pipeline
  // ----------------------------------------------------------------
  ddrs_slot_t s1_q;
  ddrs_slot_t s2_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1_q <= SLOT_IDLE;
      s2_q <= SLOT_IDLE;
    end else if (kRise) begin
      s1_q <= decodeSlot(cmdIn);
      s2_q <= s1_q;
    end
  end

  // ----------------------------------------------------------------
  // late write capture and commit
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] wbData_q;
  logic [LANES-1:0] wbStrobe_q;
  logic commit;
  logic [DATA_W-1:0] mem_q [MEM_DEPTH];
  logic [DATA_W-1:0] newBeat [2];
  logic [LANES-1:0] strobeBeat [2];
  logic [DATA_W-1:0] oldBeat [2];
  logic [DATA_W-1:0] mergedBeat [2];

  // first beat and its strobes on the k edge after the command
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wbData_q <= DATA_RESET;
      wbStrobe_q <= '1;
    end else if (kRise && s1_q.valid && !s1_q.readOp) begin
      wbData_q <= dqIn;
      wbStrobe_q <= byteWriteStrobe_n;
    end
  end

  // second beat arrives on k-bar; both beats land together then
  assign commit = !kRise && s2_q.valid && !s2_q.readOp;
  assign newBeat[0] = wbData_q;
  assign newBeat[1] = dqIn;
  assign strobeBeat[0] = wbStrobe_q;
  assign strobeBeat[1] = byteWriteStrobe_n;

  // each beat masked by its own strobes
  for (genvar b = 0; b < 2; b++) begin : gBeat
    assign oldBeat[b] = mem_q[{s2_q.addr, 1'(b)}];
    ddrs_lane_merge uMerge (
      .oldWord(oldBeat[b]),
      .newWord(newBeat[b]),
      .laneWriteStrobe_n(strobeBeat[b]),
      .mergedWord(mergedBeat[b])
    );
  end

  // all-high strobes rewrite the old word unchanged
  always_ff @(posedge mclk) begin
    if (commit) begin
      mem_q[{s2_q.addr, 1'b0}] <= mergedBeat[0];
      mem_q[{s2_q.addr, 1'b1}] <= mergedBeat[1];
    end
  end

  // ----------------------------------------------------------------
  // read data and driver enable
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dqOut_q;
  logic dqOe_n_q;
  logic kBarPhase_q;
  logic [ADDR_W-1:0] rdAddr_q;

  // two k cycles of latency, base word then base plus one
  // idle and write slots release the pins for a whole k cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dqOut_q <= DATA_RESET;
      dqOe_n_q <= 1'b1;
      rdAddr_q <= '0;
    end else if (kRise) begin
      dqOe_n_q <= !(s2_q.valid && s2_q.readOp);
      dqOut_q <= (s2_q.valid && s2_q.readOp) ? mem_q[{s2_q.addr, 1'b0}] : DATA_RESET;
      // stage two moves on at this edge, so keep the burst address for beat two
      rdAddr_q <= s2_q.addr;
    end else if (!dqOe_n_q) begin
      dqOut_q <= mem_q[{rdAddr_q, 1'b1}];
    end
  end

  // phase flag lets the controller align to k
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      kBarPhase_q <= 1'b0;
    end else begin
      kBarPhase_q <= kRise;
    end
  end

  // ----------------------------------------------------------------
  // termination range and calibration
  // ----------------------------------------------------------------
  logic selEff;
  logic termEnable_q;
  logic termStrong_q;
  logic [3:0] termRatio_q;
  logic termRangeOk_q;
  logic [5:0] termCode_q;
  logic [9:0] evalCnt_q;
  logic evalTick;

  // the pad pull-up makes a floating select read as weak
  assign selEff = terminationRangeSelectDriven ? terminationRangeSelect : 1'b1;

  // enable stays on even in reset; range follows select
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      termEnable_q <= 1'b1;
      termStrong_q <= 1'b0;
      termRatio_q <= TERM_RATIO_WEAK;
      termRangeOk_q <= 1'b0;
    end else begin
      termEnable_q <= 1'b1;
      termStrong_q <= !selEff;
      termRatio_q <= selEff ? TERM_RATIO_WEAK : TERM_RATIO_STRONG;
      termRangeOk_q <= (impedanceSetResistorOhms >= RES_MIN_OHMS) &&
        (impedanceSetResistorOhms <= (selEff ? RES_MAX_WEAK_OHMS : RES_MAX_STRONG_OHMS));
    end
  end

  assign evalTick = (evalCnt_q == EVAL_CNT_RESET);

  // evaluation timer reloads after each tick
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      evalCnt_q <= EVAL_CYCLES - EVAL_CNT_ONE;
    end else if (evalTick) begin
      evalCnt_q <= EVAL_CYCLES - EVAL_CNT_ONE;
    end else begin
      evalCnt_q <= evalCnt_q - EVAL_CNT_ONE;
    end
  end

  // one step per evaluation, so a noisy comparator cannot slam the code
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      termCode_q <= TERM_CODE_RESET;
    end else if (evalTick && impedanceTooHigh && termCode_q != TERM_CODE_MAX) begin
      termCode_q <= termCode_q + TERM_CODE_STEP;
    end else if (evalTick && impedanceTooLow && !impedanceTooHigh && termCode_q != TERM_CODE_MIN) begin
      termCode_q <= termCode_q - TERM_CODE_STEP;
    end
  end

  assign dqOut = dqOut_q;
  assign dqOe_n = dqOe_n_q;
  assign kBarPhase = kBarPhase_q;
  assign termEnable = termEnable_q;
  assign termStrong = termStrong_q;
  assign termRatioTenths = termRatio_q;
  assign termRangeOk = termRangeOk_q;
  assign termCode = termCode_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic chkValid_q;
  logic [ADDR_W-1:0] chkAddr_q;
  logic [DATA_W-1:0] chkNew_q [2];
  logic [DATA_W-1:0] chkOld_q [2];
  logic [LANES-1:0] chkStrobe_q [2];

  // snapshot of each commit for the storage checks
  always_ff @(posedge mclk) begin
    chkValid_q <= nrst && commit;
    if (commit) begin
      chkAddr_q <= s2_q.addr;
      chkNew_q <= newBeat;
      chkOld_q <= oldBeat;
      chkStrobe_q <= strobeBeat;
    end
  end

  for (genvar b = 0; b < 2; b++) begin : gChkBeat
    for (genvar g = 0; g < LANES; g++) begin : gChkLane
      lane_store_a: assert property (@(posedge mclk) disable iff (!nrst)
        chkValid_q |-> mem_q[{chkAddr_q, 1'(b)}][g*LANE_W +: LANE_W] == (chkStrobe_q[b][g] ?
          chkOld_q[b][g*LANE_W +: LANE_W] : chkNew_q[b][g*LANE_W +: LANE_W]))
        else $error("byte lane stored wrongly");
    end
  end

  write_abort_a: assert property (@(posedge mclk) disable iff (!nrst)
    chkValid_q && (&chkStrobe_q[0]) && (&chkStrobe_q[1]) |->
      mem_q[{chkAddr_q, 1'b0}] == chkOld_q[0] && mem_q[{chkAddr_q, 1'b1}] == chkOld_q[1])
    else $error("aborted write changed memory");

  read_drive_a: assert property (@(posedge mclk) disable iff (!nrst)
    kRise && isReadCmd(cmdIn) |-> ##5 (!dqOe_n_q) ##1 (!dqOe_n_q))
    else $error("read burst not driven two k cycles later");

  read_beat0_a: assert property (@(posedge mclk) disable iff (!nrst)
    kRise && s2_q.valid && s2_q.readOp |=> dqOut_q == mem_q[{$past(s2_q.addr), 1'b0}])
    else $error("first read beat not from base address");

  read_beat1_a: assert property (@(posedge mclk) disable iff (!nrst)
    !kRise && !dqOe_n_q |=> dqOut_q == $past(mem_q[{rdAddr_q, 1'b1}]))
    else $error("second read beat not from base plus one");

  pins_release_a: assert property (@(posedge mclk) disable iff (!nrst)
    kRise && !isReadCmd(cmdIn) |-> ##5 dqOe_n_q ##1 dqOe_n_q)
    else $error("drivers not off after idle or write");

  back_to_back_a: assert property (@(posedge mclk) disable iff (!nrst)
    kRise && isReadCmd(cmdIn) ##2 isReadCmd(cmdIn) |-> ##3 (!dqOe_n_q) [*4])
    else $error("back to back reads left a gap");

  term_always_a: assert property (@(posedge mclk) disable iff (!nrst)
    termEnable_q && $stable(termEnable_q))
    else $error("termination dropped");

  strong_range_a: assert property (@(posedge mclk) disable iff (!nrst)
    !selEff |=> termStrong_q && termRatio_q == TERM_RATIO_STRONG)
    else $error("strong termination not applied");

  weak_range_a: assert property (@(posedge mclk) disable iff (!nrst)
    selEff |=> !termStrong_q && termRatio_q == TERM_RATIO_WEAK)
    else $error("weak termination not applied");

  pull_default_a: assert property (@(posedge mclk) disable iff (!nrst)
    !terminationRangeSelectDriven |=> !termStrong_q)
    else $error("floating select did not pick weak range");

  code_step_a: assert property (@(posedge mclk) disable iff (!nrst)
    !evalTick |=> $stable(termCode_q))
    else $error("termination code moved between evaluations");

  eval_space_a: assert property (@(posedge mclk) disable iff (!nrst)
    evalTick |=> (!evalTick) [*8])
    else $error("evaluations too close");

endmodule : ddrs_core

//--- tb/ddrs_ctrl_model.sv
// memory controller model driving commands and write beats into the sram core
`timescale 1ns/10ps
module ddrs_ctrl_model
  import ddrs_pkg::*;
(
  // clock from the bench, phase from the core
  input wire logic mclk,
  input wire logic kBarPhase,
  // pins toward the core
  output ddrs_cmd_t cmdIn,
  output logic [DATA_W-1:0] dqIn,
  output logic [LANES-1:0] byteWriteStrobe_n
);
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // pins start at valid levels, idle is a deselect
  initial begin
    cmdIn = '{loadStrobe_n: 1'b1, readSel: 1'b0, addr: 4'h0};
    dqIn = 36'h0_0000_0000;
    byteWriteStrobe_n = 4'hF;
  end

  // drive on the k-bar edge, taken at the next k edge, then deselect
  task automatic sendCmd(input logic rd, input logic [ADDR_W-1:0] a);
    do @(posedge mclk); while (kBarPhase !== 1'b1);
    cmdIn <= '{loadStrobe_n: 1'b0, readSel: rd, addr: a};
    @(posedge mclk);
    // address flipped so a stale value cannot look valid
    cmdIn <= '{loadStrobe_n: 1'b1, readSel: 1'b0, addr: ~a};
  endtask : sendCmd

  // beat one for the next k edge, beat two for the k-bar edge
  task automatic sendWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d1, d2,
      input logic [LANES-1:0] s1, s2);
    sendCmd(1'b0, a);
    @(posedge mclk);
    dqIn <= d1;
    byteWriteStrobe_n <= s1;
    @(posedge mclk);
    dqIn <= d2;
    byteWriteStrobe_n <= s2;
    @(posedge mclk);
    // hold time over: show the inverse rather than the last beat
    dqIn <= ~d2;
    byteWriteStrobe_n <= 4'hF;
  endtask : sendWrite
endmodule : ddrs_ctrl_model

//--- tb/ddrs_core_tb.sv
// self-checking bench for the burst-of-two sram core
`timescale 1ns/10ps
module ddrs_core_tb
  import ddrs_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  ddrs_cmd_t cmdIn;
  logic [DATA_W-1:0] dqIn, dqOut;
  logic [LANES-1:0] strobeN;
  logic dqOe_n, kBarPhase, termEnable, termStrong, termRangeOk;
  logic [3:0] termRatioTenths;
  logic [5:0] termCode;
  logic sel = 1'b0, selDriven = 1'b1, tooHigh = 1'b1, tooLow = 1'b0;
  logic [9:0] ohms = 10'h15E;
  int fails = 0, n_compared = 0, cyc = 0, relC = 0;
  int dueQ[$];
  logic [DATA_W-1:0] wordQ[$];
  logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  ddrs_ctrl_model i_ctrl (.mclk(mclk), .kBarPhase(kBarPhase), .cmdIn(cmdIn), .dqIn(dqIn),
    .byteWriteStrobe_n(strobeN));

  ddrs_core i_dut (.mclk(mclk), .nrst(nrst), .cmdIn(cmdIn), .dqIn(dqIn), .byteWriteStrobe_n(strobeN),
    .dqOut(dqOut), .dqOe_n(dqOe_n), .kBarPhase(kBarPhase), .terminationRangeSelect(sel),
    .terminationRangeSelectDriven(selDriven), .impedanceSetResistorOhms(ohms),
    .impedanceTooHigh(tooHigh), .impedanceTooLow(tooLow), .termEnable(termEnable),
    .termStrong(termStrong), .termRatioTenths(termRatioTenths), .termRangeOk(termRangeOk),
    .termCode(termCode));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // reference merge: a lane changes only where its strobe is low
  function automatic logic [DATA_W-1:0] mergeLanes(input logic [DATA_W-1:0] o, n, input logic [LANES-1:0] s);
    for (int i = 0; i < LANES; i++)
      if (s[i] === 1'b0) o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
    return o;
  endfunction : mergeLanes

  task automatic doWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d1, d2,
      input logic [LANES-1:0] s1, s2);
    i_ctrl.sendWrite(a, d1, d2, s1, s2);
    mem[{a, 1'b0}] = mergeLanes(mem[{a, 1'b0}], d1, s1);
    mem[{a, 1'b1}] = mergeLanes(mem[{a, 1'b1}], d2, s2);
  endtask : doWrite

  // returns in the command edge, so cyc still holds the previous count
  task automatic doRead(input logic [ADDR_W-1:0] a);
    i_ctrl.sendCmd(1'b1, a);
    dueQ.push_back(cyc + 5);
    wordQ.push_back(mem[{a, 1'b0}]);
    dueQ.push_back(cyc + 6);
    wordQ.push_back(mem[{a, 1'b1}]);
  endtask : doRead

  task automatic termCase(input logic s, dr, input logic [9:0] o, input logic st, ok, input logic [3:0] ra);
    @(posedge mclk);
    sel <= s;
    selDriven <= dr;
    ohms <= o;
    repeat (2) @(posedge mclk);
    #1;
    check("termEnable", 36'(termEnable), 36'h1);
    check("termStrong", 36'(termStrong), 36'(st));
    check("termRatioTenths", 36'(termRatioTenths), 36'(ra));
    check("termRangeOk", 36'(termRangeOk), 36'(ok));
  endtask : termCase

  // ----------------------------------------------------------------
  // monitor and timeout
  // ----------------------------------------------------------------
  // every cycle is either a scheduled read beat or drivers off
  always @(negedge mclk) begin
    if (nrst === 1'b1) begin
      if (dueQ.size() > 0 && dueQ[0] == cyc) begin
        check("dqOe_n read", 36'(dqOe_n), 36'h0);
        check("dqOut", dqOut, wordQ[0]);
        void'(dueQ.pop_front());
        void'(wordQ.pop_front());
      end else begin
        check("dqOe_n idle", 36'(dqOe_n), 36'h1);
        check("dqOut idle", dqOut, 36'h0_0000_0000);
      end
    end
  end

  always @(posedge mclk) begin
    if (cyc == 4000) begin
      fails++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (19) @(posedge mclk);
    #1;
    check("termCode reset", 36'(termCode), 36'h20);
    @(posedge mclk);
    nrst <= 1'b1;
    relC = cyc + 2;
    // prime every word with both beats strobed
    for (int a = 0; a < 16; a++)
      doWrite(4'(a), {4{9'(a)}}, {4{9'(a + 16)}}, 4'h0, 4'h0);
    // every lane code, each lane in one beat only
    for (int i = 0; i < 16; i++)
      doWrite(4'(i), {4{9'h1A5}}, {4{9'h05A}}, 4'(i), ~4'(i));
    // all strobes high leaves the word alone
    doWrite(4'h3, 36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF, 4'hF, 4'hF);
    for (int a = 0; a < 16; a++)
      doRead(4'(a));
    repeat (8) @(posedge mclk);
    $display("test lanes done");
    // weak range changes nothing on the data path
    @(posedge mclk);
    sel <= 1'b1;
    doWrite(4'h5, 36'h1_2345_6789, 36'h9_8765_4321, 4'h5, 4'hA);
    doRead(4'h5);
    doRead(4'h6);
    repeat (8) @(posedge mclk);
    $display("test weak range done");
    termCase(1'b0, 1'b1, 10'h15E, 1'b1, 1'b1, 4'h3);
    termCase(1'b0, 1'b1, 10'h15F, 1'b1, 1'b0, 4'h3);
    termCase(1'b1, 1'b1, 10'h0FA, 1'b0, 1'b1, 4'h6);
    termCase(1'b1, 1'b1, 10'h0FB, 1'b0, 1'b0, 4'h6);
    termCase(1'b0, 1'b0, 10'h0AF, 1'b0, 1'b1, 4'h6);
    termCase(1'b1, 1'b1, 10'h0AE, 1'b0, 1'b0, 4'h6);
    $display("test termination done");
    while (cyc < relC + 990) @(posedge mclk);
    #1;
    check("termCode before tick", 36'(termCode), 36'h20);
    while (cyc < relC + 1010) @(posedge mclk);
    #1;
    check("termCode up", 36'(termCode), 36'h21);
    @(posedge mclk);
    tooHigh <= 1'b0;
    tooLow <= 1'b1;
    while (cyc < relC + 3010) @(posedge mclk);
    #1;
    check("termCode down", 36'(termCode), 36'h1F);
    $display("test calibration done");
    final_report();
  end
endmodule : ddrs_core_tb
